// *** pkg/csr_map.svh ***
// Offsets, field positions and reset values of the core system registers.
// Assumes inclusion by bare name from the package, csr_stack_ptr and csr_core_regs.
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH

// Register offsets in the register file address space
`define CSR_OFS_WPTR_FIRST   8'hE8
`define CSR_OFS_WPTR_SECOND  8'hE9
`define CSR_OFS_PAGE_SEL     8'hEA
`define CSR_OFS_OPER_CTRL    8'hEB
`define CSR_OFS_UPTR_HIGH    8'hEC
`define CSR_OFS_UPTR_LOW     8'hED
`define CSR_OFS_SPTR_HIGH    8'hEE
`define CSR_OFS_SPTR_LOW     8'hEF

// Field positions
`define CSR_BLOCK_MSB        7
`define CSR_BLOCK_LSB        3
`define CSR_PTR_MODE_BIT     2
`define CSR_PAGE_MSB         7
`define CSR_PAGE_LSB         2
`define CSR_SYS_LOC_BIT      7
`define CSR_USR_LOC_BIT      6
`define CSR_HALVER_BIT       5
`define CSR_DIVIDER_MSB      4
`define CSR_DIVIDER_LSB      2
`define CSR_BRQ_GATE_BIT     1
`define CSR_FLOAT_BIT        0

// Reset values
`define CSR_OPER_CTRL_RST    8'hE0
`define CSR_PTR_RST          8'h00
`define CSR_PAGE_RST         8'h00
`define CSR_STACK_RST        16'h0000

// Sizes
`define CSR_PAGE_COUNT       64
`define CSR_BUS_LINES        16
`define CSR_MAX_PUSH         3'h4

`endif

// *** pkg/csr_pkg.sv ***
// Types shared by the core system register group.
// Assumes the constant header is on the include path.
package csr_pkg;
  `include "csr_map.svh"

  typedef logic [7:0]  csr_byte_t;
  typedef logic [15:0] csr_word_t;

  typedef enum logic {
    SEQ_IDLE,
    SEQ_PUSH
  } csr_seq_e;
endpackage : csr_pkg

// *** verilog/csr_clk_div.sv ***
// Oscillator halver followed by the core clock prescaler.
// Assumes it runs on the oscillator clock; produces one-cycle tick pulses.
`timescale 1ns/1ps
module csr_clk_div (
  input  wire logic       refClk,
  input  wire logic       rst,
  input  wire logic       halve,
  input  wire logic [2:0] divider,
  output logic            intTick,
  output logic            coreTick
);
  import csr_pkg::*;

  logic       phase_q;
  logic [2:0] count_q;
  logic       halfTick;

  // Halved clock gives a tick every other edge
  assign halfTick = halve ? phase_q : 1'b1;

  always_ff @(posedge refClk or posedge rst) begin
    if (rst) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
    end
  end

  always_ff @(posedge refClk or posedge rst) begin
    if (rst) begin
      count_q  <= 3'h0;
      intTick  <= 1'b0;
      coreTick <= 1'b0;
    end else begin
      intTick  <= halfTick;
      coreTick <= 1'b0;
      if (halfTick) begin
        // Field value n divides by n plus one
        if (count_q >= divider) begin
          count_q  <= 3'h0;
          coreTick <= 1'b1;
        end else begin
          count_q <= count_q + 3'h1;
        end
      end
    end
  end
endmodule : csr_clk_div

// *** verilog/csr_stack_ptr.sv ***
// One double-byte stack pointer with pre-decrement push, post-increment pop.
// Assumes the owner never pushes, pops and writes in conflicting ways.
`timescale 1ns/1ps
`include "csr_map.svh"
module csr_stack_ptr (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        inRegFile,
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic        wrHigh,
  input  wire logic        wrLow,
  input  wire logic [7:0]  wrData,
  output logic      [15:0] ptr,
  output logic      [15:0] pushAddr
);
  import csr_pkg::*;

  logic [15:0] incAddr;

  // Register file stacks only move the low byte; high byte is left alone
  always_comb begin
    if (inRegFile) begin
      pushAddr = {ptr[15:8], ptr[7:0] - 8'h01};
      incAddr  = {ptr[15:8], ptr[7:0] + 8'h01};
    end else begin
      pushAddr = ptr - 16'h0001;
      incAddr  = ptr + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr <= `CSR_STACK_RST;
    end else if (push) begin
      ptr <= pushAddr;
    end else if (pop) begin
      ptr <= incAddr;
    end else begin
      if (wrHigh) begin
        ptr[15:8] <= wrData;
      end
      if (wrLow) begin
        ptr[7:0] <= wrData;
      end
    end
  end
endmodule : csr_stack_ptr

// *** verilog/csr_core_regs.sv ***
// Core system register group: working pointers, page selector, operating
// control, stack pointers and automatic stacking for interrupts and calls.
// Assumes one core clock, instruction strobes from the executing logic and
// a register file port that reads with one cycle of latency.
//
// How it works
// - First pointer keeps a 0..31 block number in bits 7:3.
// - Single mode maps sixteen registers from the block; twin maps r0-r7.
// - Twin set-pointer sets mode bit in both pointers; single clears it.
// - Pointer bits 1:0 always read zero.
// - Second pointer holds its block in bits 7:3 and maps r8-r15.
// - Page selector holds page 0..63 in bits 7:2, low bits read zero.
// - Paged group shows one of 64 pages, valid only if present.
// - Interrupt entry never stacks the page selector.
// - Control resets to E0h; bit 7 picks system stack location.
// - Control bit 6 picks user stack location.
// - Control bit 5 halves the oscillator clock.
// - Control bits 4:2 set core clock division from 1 to 8.
// - Control bit 1 gates the external bus request input.
// - Control bit 0 floats bus port lines and strobes only.
// - Push pre-decrements the pointer, pop post-increments it.
// - Pop never writes stack memory.
// - Interrupt entry stacks PC and flags, plus code segment if enabled.
// - Near call stacks PC; segment call stacks PC and code segment.
// - Register file stacks use only the pointer low byte.
// - Odd single-mode block numbers round down to even.
`timescale 1ns/1ps
`include "csr_map.svh"
module csr_core_regs (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Register file port
  input  wire logic [7:0]           regAddr,
  input  wire logic                 regWrEn,
  input  wire logic [7:0]           regWrData,
  input  wire logic                 regRdEn,
  output logic      [7:0]           regRdData,
  output logic                      regRdHit,
  // Set-pointer and set-page instructions
  input  wire logic                 setSinglePtr,
  input  wire logic                 setFirstTwinPtr,
  input  wire logic                 setSecondTwinPtr,
  input  wire logic [4:0]           blockNumber,
  input  wire logic                 setPage,
  input  wire logic [5:0]           pageNumber,
  // Working register mapping
  input  wire logic [3:0]           workRegIndex,
  output logic      [7:0]           workRegAddr,
  // Paged group
  input  wire logic [63:0]          pagePresent,
  output logic      [5:0]           pageSelected,
  output logic                      pageValid,
  // Clock control
  output logic                      intClkTick,
  output logic                      coreClkTick,
  // External bus control
  input  wire logic                 bus_request_pin,
  output logic                      busRequest,
  input  wire logic [15:0]          portLineIsBus,
  output logic      [15:0]          portLineFloat,
  output logic                      strobeFloat,
  // Automatic stacking and stack instructions
  input  wire logic                 irqEntry,
  input  wire logic                 callNear,
  input  wire logic                 callSegment,
  input  wire logic                 segment_push_enable,
  input  wire logic [15:0]          progCounter,
  input  wire logic [7:0]           flagReg,
  input  wire logic [7:0]           codeSegment,
  input  wire logic                 stackOpReq,
  input  wire logic                 stackOpPop,
  input  wire logic                 stackOpUser,
  input  wire logic [7:0]           stackOpData,
  output logic                      stackBusy,
  output logic                      stackWrEn,
  output logic                      stackRdEn,
  output logic      [15:0]          stackAddr,
  output logic      [7:0]           stackWrData,
  output logic                      stackInMemory
);
  import csr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  csr_byte_t   firstPtr_q;
  csr_byte_t   secondPtr_q;
  csr_byte_t   pageSel_q;
  csr_byte_t   operCtrl_q;
  csr_word_t   userPtr;
  csr_word_t   sysPtr;
  csr_word_t   userPushAddr;
  csr_word_t   sysPushAddr;
  csr_seq_e    seqState_q;
  csr_byte_t   pushBytes_q [0:3];
  logic [2:0]  pushLeft_q;
  logic        brqMeta_q;
  logic        brqSync_q;
  logic        wrFirst;
  logic        wrSecond;
  logic        wrPage;
  logic        wrCtrl;
  logic        startSeq;
  logic        byteOp;
  logic        userPush;
  logic        userPop;
  logic        sysPush;
  logic        sysPop;
  logic        seqPush;
  logic [4:0]  evenBlock;
  logic [7:0]  mapAddr;
  logic        twinMode;
  logic        userInRf;
  logic        sysInRf;

  assign wrFirst  = regWrEn && (regAddr == `CSR_OFS_WPTR_FIRST);
  assign wrSecond = regWrEn && (regAddr == `CSR_OFS_WPTR_SECOND);
  assign wrPage   = regWrEn && (regAddr == `CSR_OFS_PAGE_SEL);
  assign wrCtrl   = regWrEn && (regAddr == `CSR_OFS_OPER_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Working register pointers

  // Instructions win over a register write in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      firstPtr_q <= `CSR_PTR_RST;
    end else if (setSinglePtr) begin
      firstPtr_q <= {blockNumber, 3'b000};
    end else if (setFirstTwinPtr) begin
      firstPtr_q <= {blockNumber, 3'b100};
    end else if (setSecondTwinPtr) begin
      firstPtr_q[`CSR_PTR_MODE_BIT] <= 1'b1;
    end else if (wrFirst) begin
      firstPtr_q <= {regWrData[7:2], 2'b00};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      secondPtr_q <= `CSR_PTR_RST;
    end else if (setSecondTwinPtr) begin
      secondPtr_q <= {blockNumber, 3'b100};
    end else if (setFirstTwinPtr) begin
      secondPtr_q[`CSR_PTR_MODE_BIT] <= 1'b1;
    end else if (setSinglePtr) begin
      secondPtr_q[`CSR_PTR_MODE_BIT] <= 1'b0;
    end else if (wrSecond) begin
      secondPtr_q <= {regWrData[7:2], 2'b00};
    end
  end

  assign twinMode  = firstPtr_q[`CSR_PTR_MODE_BIT];
  // Odd block keeps sixteen registers on a 16-register boundary
  assign evenBlock = {firstPtr_q[7:4], 1'b0};

  always_comb begin
    if (!twinMode) begin
      mapAddr = {evenBlock, 3'b000} + {4'h0, workRegIndex};
    end else if (!workRegIndex[3]) begin
      mapAddr = {firstPtr_q[7:3], workRegIndex[2:0]};
    end else begin
      mapAddr = {secondPtr_q[7:3], workRegIndex[2:0]};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      workRegAddr <= 8'h00;
    end else begin
      workRegAddr <= mapAddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page selector

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pageSel_q <= `CSR_PAGE_RST;
    end else if (setPage) begin
      pageSel_q <= {pageNumber, 2'b00};
    end else if (wrPage) begin
      pageSel_q <= {regWrData[7:2], 2'b00};
    end
  end

  // An absent peripheral leaves its page empty
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pageSelected <= 6'h00;
      pageValid    <= 1'b0;
    end else begin
      pageSelected <= pageSel_q[7:2];
      pageValid    <= pagePresent[pageSel_q[7:2]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating control

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      operCtrl_q <= `CSR_OPER_CTRL_RST;
    end else if (wrCtrl) begin
      operCtrl_q <= regWrData;
    end
  end

  csr_clk_div uClkDiv (
    .refClk   (ref_clk),
    .rst      (rst),
    .halve    (operCtrl_q[`CSR_HALVER_BIT]),
    .divider  (operCtrl_q[`CSR_DIVIDER_MSB:`CSR_DIVIDER_LSB]),
    .intTick  (intClkTick),
    .coreTick (coreClkTick)
  );

  // Pin is asynchronous; second flop alone feeds the gate
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      brqMeta_q  <= 1'b0;
      brqSync_q  <= 1'b0;
      busRequest <= 1'b0;
    end else begin
      brqMeta_q  <= bus_request_pin;
      brqSync_q  <= brqMeta_q;
      busRequest <= brqSync_q && operCtrl_q[`CSR_BRQ_GATE_BIT];
    end
  end

  // Lines left as plain I/O are never floated
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      portLineFloat <= 16'h0000;
      strobeFloat   <= 1'b0;
    end else begin
      portLineFloat <= portLineIsBus & {16{operCtrl_q[`CSR_FLOAT_BIT]}};
      strobeFloat   <= operCtrl_q[`CSR_FLOAT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack pointers

  assign sysInRf  = operCtrl_q[`CSR_SYS_LOC_BIT];
  assign userInRf = operCtrl_q[`CSR_USR_LOC_BIT];

  assign startSeq = (seqState_q == SEQ_IDLE) &&
                    (irqEntry || callNear || callSegment);
  assign byteOp   = (seqState_q == SEQ_IDLE) && !startSeq && stackOpReq;
  assign seqPush  = (seqState_q == SEQ_PUSH);
  assign userPush = byteOp && stackOpUser && !stackOpPop;
  assign userPop  = byteOp && stackOpUser && stackOpPop;
  assign sysPush  = seqPush || (byteOp && !stackOpUser && !stackOpPop);
  assign sysPop   = byteOp && !stackOpUser && stackOpPop;
  assign stackBusy = seqPush;

  csr_stack_ptr uUserPtr (
    .clk       (ref_clk),
    .rst       (rst),
    .inRegFile (userInRf),
    .push      (userPush),
    .pop       (userPop),
    .wrHigh    (regWrEn && (regAddr == `CSR_OFS_UPTR_HIGH)),
    .wrLow     (regWrEn && (regAddr == `CSR_OFS_UPTR_LOW)),
    .wrData    (regWrData),
    .ptr       (userPtr),
    .pushAddr  (userPushAddr)
  );

  csr_stack_ptr uSysPtr (
    .clk       (ref_clk),
    .rst       (rst),
    .inRegFile (sysInRf),
    .push      (sysPush),
    .pop       (sysPop),
    .wrHigh    (regWrEn && (regAddr == `CSR_OFS_SPTR_HIGH)),
    .wrLow     (regWrEn && (regAddr == `CSR_OFS_SPTR_LOW)),
    .wrData    (regWrData),
    .ptr       (sysPtr),
    .pushAddr  (sysPushAddr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Automatic stacking sequencer

  // Bytes go out PC low, PC high, then flags and/or code segment; page selector stays
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seqState_q <= SEQ_IDLE;
      pushLeft_q <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        pushBytes_q[i] <= 8'h00;
      end
    end else begin
      case (seqState_q)
        SEQ_IDLE: begin
          if (startSeq) begin
            seqState_q     <= SEQ_PUSH;
            pushBytes_q[0] <= progCounter[7:0];
            pushBytes_q[1] <= progCounter[15:8];
            if (irqEntry) begin
              pushBytes_q[2] <= flagReg;
              pushBytes_q[3] <= codeSegment;
              pushLeft_q     <= segment_push_enable ? `CSR_MAX_PUSH
                                                    : 3'h3;
            end else if (callSegment) begin
              pushBytes_q[2] <= codeSegment;
              pushBytes_q[3] <= 8'h00;
              pushLeft_q     <= 3'h3;
            end else begin
              pushBytes_q[2] <= 8'h00;
              pushBytes_q[3] <= 8'h00;
              pushLeft_q     <= 3'h2;
            end
          end
        end
        SEQ_PUSH: begin
          for (int i = 0; i < 3; i++) begin
            pushBytes_q[i] <= pushBytes_q[i + 1];
          end
          pushBytes_q[3] <= 8'h00;
          pushLeft_q     <= pushLeft_q - 3'h1;
          if (pushLeft_q == 3'h1) begin
            seqState_q <= SEQ_IDLE;
          end
        end
        default: begin
          seqState_q <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Memory strobes: push writes at the decremented address, pop reads the
  // current one and writes nothing
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stackWrEn     <= 1'b0;
      stackRdEn     <= 1'b0;
      stackAddr     <= 16'h0000;
      stackWrData   <= 8'h00;
      stackInMemory <= 1'b0;
    end else begin
      stackWrEn <= userPush || sysPush;
      stackRdEn <= userPop || sysPop;
      if (userPush) begin
        stackAddr     <= userPushAddr;
        stackWrData   <= stackOpData;
        stackInMemory <= !userInRf;
      end else if (sysPush) begin
        stackAddr     <= sysPushAddr;
        stackWrData   <= seqPush ? pushBytes_q[0] : stackOpData;
        stackInMemory <= !sysInRf;
      end else if (userPop) begin
        stackAddr     <= userPtr;
        stackInMemory <= !userInRf;
      end else if (sysPop) begin
        stackAddr     <= sysPtr;
        stackInMemory <= !sysInRf;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdData <= 8'h00;
      regRdHit  <= 1'b0;
    end else begin
      regRdHit  <= 1'b0;
      regRdData <= 8'h00;
      if (regRdEn) begin
        regRdHit <= 1'b1;
        case (regAddr)
          `CSR_OFS_WPTR_FIRST:  regRdData <= firstPtr_q;
          `CSR_OFS_WPTR_SECOND: regRdData <= secondPtr_q;
          `CSR_OFS_PAGE_SEL:    regRdData <= pageSel_q;
          `CSR_OFS_OPER_CTRL:   regRdData <= operCtrl_q;
          `CSR_OFS_UPTR_HIGH:   regRdData <= userPtr[15:8];
          `CSR_OFS_UPTR_LOW:    regRdData <= userPtr[7:0];
          `CSR_OFS_SPTR_HIGH:   regRdData <= sysPtr[15:8];
          `CSR_OFS_SPTR_LOW:    regRdData <= sysPtr[7:0];
          default:              regRdHit  <= 1'b0;
        endcase
      end
    end
  end
endmodule : csr_core_regs

// *** tb/csr_core_regs_asserts.sv ***
// Port-level checker for the core system register group.
// Assumes it is bound onto csr_core_regs and sees only its ports.
`timescale 1ns/1ps
module csr_core_regs_asserts (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  regAddr,
  input wire logic        regRdEn,
  input wire logic [7:0]  regRdData,
  input wire logic        regRdHit,
  input wire logic        bus_request_pin,
  input wire logic        busRequest,
  input wire logic [15:0] portLineIsBus,
  input wire logic [15:0] portLineFloat,
  input wire logic        irqEntry,
  input wire logic        callNear,
  input wire logic        callSegment,
  input wire logic        segment_push_enable,
  input wire logic        stackOpReq,
  input wire logic        stackOpPop,
  input wire logic        stackBusy,
  input wire logic        stackWrEn,
  input wire logic        stackRdEn
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic idle;
  // A byte op only counts when no frame start can pre-empt it
  assign idle = !stackBusy && !irqEntry && !callNear && !callSegment;
  ////////////////////////////////////////////////////////////
  ptr_low_zero_a: assert property (
    regRdEn && regAddr inside {8'hE8, 8'hE9}
    |=> regRdHit && regRdData[1:0] == 2'b00) else $error("pointer low bits");
  page_low_zero_a: assert property (
    regRdEn && regAddr == 8'hEA |=> regRdHit && regRdData[1:0] == 2'b00)
    else $error("page low bits");
  byte_push_a: assert property (
    stackOpReq && !stackOpPop && idle |=> stackWrEn && !stackRdEn)
    else $error("byte push strobe");
  pop_no_write_a: assert property (
    stackOpReq && stackOpPop && idle |=> stackRdEn && !stackWrEn)
    else $error("pop wrote stack");
  near_call_a: assert property (
    callNear && !callSegment && !irqEntry && !stackBusy
    |=> stackBusy ##1 stackWrEn[*2] ##1 !stackWrEn) else $error("near call");
  seg_call_a: assert property (
    callSegment && !irqEntry && !stackBusy
    |=> stackBusy ##1 stackWrEn[*3] ##1 !stackWrEn) else $error("seg call");
  irq_short_a: assert property (
    irqEntry && !stackBusy && !segment_push_enable
    |=> stackBusy ##1 stackWrEn[*3] ##1 !stackWrEn) else $error("irq frame");
  irq_long_a: assert property (
    irqEntry && !stackBusy && segment_push_enable
    |=> stackBusy ##1 stackWrEn[*4] ##1 !stackWrEn) else $error("irq seg");
  bus_req_a: assert property (
    busRequest |-> $past(bus_request_pin, 3)) else $error("bus request");
  float_only_a: assert property (
    $stable(portLineIsBus) |-> (portLineFloat & ~portLineIsBus) == 16'h0000)
    else $error("plain line floated");
  cover property (irqEntry && !stackBusy && segment_push_enable);
  cover property (callSegment && !stackBusy);
  cover property (busRequest);
endmodule : csr_core_regs_asserts

bind csr_core_regs csr_core_regs_asserts i_chk (.ref_clk, .rst, .regAddr,
  .regRdEn, .regRdData, .regRdHit, .bus_request_pin, .busRequest,
  .portLineIsBus, .portLineFloat, .irqEntry, .callNear, .callSegment,
  .segment_push_enable, .stackOpReq, .stackOpPop, .stackBusy, .stackWrEn,
  .stackRdEn);

// *** tb/csr_core_regs_bench.sv ***
// Self-checking bench for the core system register group.
// Assumes csr_pkg is compiled first; inputs move 1 ns after the edge.
`timescale 1ns/1ps
module csr_core_regs_bench;
  import csr_pkg::*;
  logic        ref_clk, rst, regWrEn, regRdEn, regRdHit, setSinglePtr;
  logic        setFirstTwinPtr, setSecondTwinPtr, setPage, pageValid, hit;
  logic        intClkTick, coreClkTick, bus_request_pin, busRequest;
  logic        strobeFloat, irqEntry, callNear, callSegment, stackOpReq;
  logic        segment_push_enable, stackOpPop, stackOpUser, stackBusy;
  logic        stackWrEn, stackRdEn, stackInMemory;
  csr_byte_t   regAddr, regWrData, regRdData, workRegAddr, flagReg;
  csr_byte_t   codeSegment, stackOpData, stackWrData;
  logic [3:0]  workRegIndex;
  logic [4:0]  blockNumber;
  logic [5:0]  pageNumber, pageSelected;
  logic [63:0] pagePresent;
  csr_word_t   portLineIsBus, portLineFloat, progCounter, stackAddr;
  logic [23:0] wq[$];
  int          fail_count, checked, rdCount, n, h;

  csr_core_regs i_dut (.ref_clk, .rst, .regAddr, .regWrEn, .regWrData,
    .regRdEn, .regRdData, .regRdHit, .setSinglePtr, .setFirstTwinPtr,
    .setSecondTwinPtr, .blockNumber, .setPage, .pageNumber, .workRegIndex,
    .workRegAddr, .pagePresent, .pageSelected, .pageValid, .intClkTick,
    .coreClkTick, .bus_request_pin, .busRequest, .portLineIsBus,
    .portLineFloat, .strobeFloat, .irqEntry, .callNear, .callSegment,
    .segment_push_enable, .progCounter, .flagReg, .codeSegment, .stackOpReq,
    .stackOpPop, .stackOpUser, .stackOpData, .stackBusy, .stackWrEn,
    .stackRdEn, .stackAddr, .stackWrData, .stackInMemory);

  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Strobes stand one cycle; the falling edge sees them settled
  always @(negedge ref_clk) begin
    if (stackWrEn === 1'b1) wq.push_back({stackAddr, stackWrData});
    if (stackRdEn === 1'b1) rdCount++;
  end
  ////////////////////////////////////////////////////////////
  task complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task chk8(string nm, csr_byte_t e, csr_byte_t g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task chk16(string nm, csr_word_t e, csr_word_t g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk16
  task step(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : step
  // Each transfer ends with an idle cycle so strobes never re-rise at once
  task wr(csr_byte_t a, csr_byte_t d);
    regAddr = a; regWrData = d; regWrEn = 1; step(1); regWrEn = 0; step(1);
  endtask : wr
  task rdc(csr_byte_t a, csr_byte_t e, csr_byte_t m = 8'hFF);
    regAddr = a; regRdEn = 1; step(1); regRdEn = 0;
    hit = regRdHit;
    chk8("read data", e, regRdData & m);
    step(1);
  endtask : rdc
  task automatic pulse(ref logic s);
    s = 1; step(1); s = 0; step(1);
  endtask : pulse
  function csr_byte_t wmap(logic tw, logic [4:0] a, b, logic [3:0] i);
    return !tw ? {a[4:1], i} : {i[3] ? b : a, i[2:0]};
  endfunction : wmap
  task chkmap(logic tw, logic [4:0] a, logic [4:0] b);
    for (int i = 0; i < 16; i += 5) begin
      workRegIndex = 4'(i); step(2);
      chk8("work register", wmap(tw, a, b, 4'(i)), workRegAddr);
    end
  endtask : chkmap
  task wait_idle;
    for (int i = 0; i < 20 && stackBusy !== 1'b0; i++) step(1);
    if (stackBusy !== 1'b0) begin
      fail_count++;
      complete_run;
    end
    step(3);
  endtask : wait_idle
  task frame(csr_word_t top, int nb, logic [31:0] v);
    logic [23:0] e;
    for (int k = 0; k < nb; k++) begin
      e = wq.size() > 0 ? wq.pop_front() : 24'hFF_FFFF;
      chk16("stack address", top - 16'(k), e[23:8]);
      chk8("stack data", v[8*k +: 8], e[7:0]);
    end
    chk8("extra pushes", 8'h00, 8'(wq.size()));
  endtask : frame
  task ticks(int len, output int ci, output int cc);
    ci = 0; cc = 0;
    repeat (len) begin
      @(negedge ref_clk);
      ci += (intClkTick === 1'b1);
      cc += (coreClkTick === 1'b1);
    end
    step(1);
  endtask : ticks
  ////////////////////////////////////////////////////////////
  initial begin
    csr_byte_t d;
    logic [4:0] a, b;
    logic [5:0] p;
    csr_word_t pc;
    int ci, cc;
    {regAddr, regWrEn, regWrData, regRdEn, setSinglePtr, setFirstTwinPtr,
     setSecondTwinPtr, blockNumber, setPage, pageNumber, workRegIndex,
     pagePresent, bus_request_pin, portLineIsBus, irqEntry, callNear,
     callSegment, segment_push_enable, progCounter, flagReg, codeSegment,
     stackOpReq, stackOpPop, stackOpUser, stackOpData} = '0;
    rst = 1; fail_count = 0; checked = 0; rdCount = 0;
    void'($urandom(32'hd39156fb));
    step(2); rst = 0; step(1);
    rdc(8'hEB, 8'hE0);
    rdc(8'hE8, 8'h00); rdc(8'hEA, 8'h00);
    rdc(8'h37, 8'h00);
    chk8("read hit", 8'h00, {7'h00, hit});
    repeat (4) begin
      d = 8'($urandom); wr(8'hEB, d);
      rdc(8'hEB, d);
      wr(8'hE8, d); rdc(8'hE8, d & 8'hFC);
      wr(8'hE9, ~d); rdc(8'hE9, ~d & 8'hFC);
      wr(8'hEA, d); rdc(8'hEA, d & 8'hFC);
    end
    repeat (6) begin
      // Odd blocks exercise the round-down of single mode
      a = 5'($urandom) | 5'h01; b = 5'($urandom);
      blockNumber = a; pulse(setSinglePtr);
      rdc(8'hE8, 8'h00, 8'h07);
      chkmap(0, a, b);
      pulse(setFirstTwinPtr); blockNumber = b; pulse(setSecondTwinPtr);
      rdc(8'hE8, {a, 3'b100});
      rdc(8'hE9, {b, 3'b100});
      chkmap(1, a, b);
      blockNumber = a; pulse(setSinglePtr);
      rdc(8'hE9, 8'h00, 8'h07);
    end
    repeat (4) begin
      p = 6'($urandom); pagePresent = {$urandom, $urandom};
      pageNumber = p; pulse(setPage); step(1);
      rdc(8'hEA, {p, 2'b00});
      chk8("page", {2'b00, p}, {2'b00, pageSelected});
      chk8("page ok", {7'h00, pagePresent[p]}, {7'h00, pageValid});
    end
    for (h = 0; h < 2; h++) for (n = 0; n < 8; n++) begin
      wr(8'hEB, 8'(8'hC0 | h << 5 | n << 2)); step(20);
      ticks(4 * (n + 1) * (h + 1), ci, cc);
      chk8("int ticks", 8'(4 * (n + 1)), 8'(ci));
      chk8("core ticks", 8'h04, 8'(cc));
    end
    portLineIsBus = 16'($urandom); bus_request_pin = 1;
    wr(8'hEB, 8'hC3); step(4);
    chk8("bus request", 8'h01, {7'h00, busRequest});
    chk16("float", portLineIsBus, portLineFloat);
    chk8("strobe float", 8'h01, {7'h00, strobeFloat});
    wr(8'hEB, 8'hC0); step(4);
    chk8("bus request", 8'h00, {7'h00, busRequest});
    chk16("float", 16'h0000, portLineFloat);
    wr(8'hEE, 8'h00); wr(8'hEF, 8'hC0);
    pc = 16'($urandom); progCounter = pc;
    flagReg = 8'($urandom); codeSegment = 8'($urandom);
    pulse(callNear); wait_idle;
    frame(16'h00BF, 2, {16'h0000, pc});
    chk8("in memory", 8'h00, {7'h00, stackInMemory});
    rdc(8'hEF, 8'hBE);
    pulse(irqEntry); wait_idle;
    frame(16'h00BD, 3, {codeSegment, flagReg, pc});
    segment_push_enable = 1; pulse(irqEntry); wait_idle;
    frame(16'h00BA, 4, {codeSegment, flagReg, pc});
    pulse(callSegment); wait_idle;
    frame(16'h00B6, 3, {8'h00, codeSegment, pc});
    wr(8'hEB, 8'h40); pulse(callNear); wait_idle;
    chk8("in memory", 8'h01, {7'h00, stackInMemory});
    frame(16'h00B3, 2, {16'h0000, pc});
    wr(8'hEB, 8'hC0); wr(8'hEC, 8'h00); wr(8'hED, 8'h80);
    d = 8'($urandom); stackOpData = d; stackOpUser = 1;
    pulse(stackOpReq); step(2);
    frame(16'h007F, 1, {24'h00_0000, d});
    rdc(8'hED, 8'h7F);
    stackOpPop = 1; pulse(stackOpReq); step(2);
    chk8("pops", 8'h01, 8'(rdCount));
    chk16("pop address", 16'h007F, stackAddr);
    frame(16'h0000, 0, 32'h0000_0000);
    rdc(8'hED, 8'h80);
    stackOpPop = 0; stackOpUser = 0; wr(8'hEE, 8'h12); wr(8'hEF, 8'hD0);
    pulse(stackOpReq); step(2);
    rdc(8'hEF, 8'hCF); rdc(8'hEE, 8'h12);
    complete_run;
  end
endmodule : csr_core_regs_bench
